// [core/i2c_slave_stretch_addr_hold.v]
// i2c slave engine with address/data hold, clock stretching and 10-bit addressing
`timescale 1ns/100ps
`default_nettype none
`include "i2c_slave_defines.vh"
module i2c_slave_stretch_addr_hold #(
  parameter DATA_W = `DATA_WIDTH,
  parameter FIFO_DEPTH = `FIFO_DEPTH,
  parameter FIFO_AW = `FIFO_AW
) (
  input wire CLK_IN,
  input wire SYS_RST_IN,
  input wire SCL_IN,
  input wire SDA_IN,
  output wire SCL_OUT,
  output wire SCL_OE_N_OUT,
  output wire SDA_OUT,
  output wire SDA_OE_N_OUT,
  input wire ADDR_HOLD_EN_IN,
  input wire DATA_HOLD_EN_IN,
  input wire STRETCH_EN_IN,
  input wire START_IRQ_EN_IN,
  input wire TEN_BIT_EN_IN,
  input wire ACK_VALUE_IN,
  input wire CLK_RELEASE_SET_IN,
  input wire IRQ_CLEAR_IN,
  input wire ADDR_WR_IN,
  input wire [7:0] ADDR_WR_DATA_IN,
  input wire TX_WR_IN,
  input wire [7:0] TX_DATA_IN,
  input wire RX_READY_IN,
  output wire RX_VALID_OUT,
  output wire [DATA_W-1:0] RX_DATA_OUT,
  output wire SERIAL_IRQ_FLAG_OUT,
  output wire CLOCK_RELEASE_BIT_OUT,
  output wire BUFFER_FULL_FLAG_OUT,
  output wire UPDATE_ADDRESS_FLAG_OUT,
  output wire ACK_TIMING_STATUS_OUT,
  output wire RECEIVED_ACK_STATUS_OUT,
  output wire READ_WRITE_STATUS_OUT,
  output wire DATA_ADDRESS_STATUS_OUT,
  output wire START_SEEN_OUT,
  output wire [7:0] SLAVE_ADDRESS_OUT
);
  // ----------------------------------------
  // states and byte kinds
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_RECV = 3'h1;
  localparam ST_HOLD = 3'h2;
  localparam ST_ACK = 3'h3;
  localparam ST_TX = 3'h4;
  localparam ST_TXACK = 3'h5;
  localparam KIND_ADDR = 2'h0;
  localparam KIND_LOW = 2'h1;
  localparam KIND_DATA = 2'h2;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  wire [1:0] pins_sync;
  wire scl_s;
  wire sda_s;
  reg scl_d;
  reg sda_d;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  reg [2:0] state;
  reg [3:0] cnt;
  reg [7:0] shreg;
  reg [7:0] tx_sh;
  reg [1:0] kind;
  reg [1:0] kind_after;
  reg ack_drive;
  reg ua_pending;
  reg ten_matched;
  reg scl_oe_n;
  reg sda_oe_n;
  reg serial_irq_flag;
  reg clock_release_bit;
  reg buffer_full_flag;
  reg update_address_flag;
  reg ack_timing_status;
  reg received_ack_status;
  reg read_write;
  reg data_address;
  reg start_seen;
  reg [7:0] slave_address_reg;
  reg fifo_in_valid;
  reg [DATA_W-1:0] fifo_in_data;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [DATA_W-1:0] fifo_out_data;
  wire fifo_drain;
  reg rx_valid;
  reg [DATA_W-1:0] rx_data;
  wire rx_pop;
  wire first_hit;
  wire need_hold;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // first byte: 7-bit compare, or 10-bit prefix plus two high bits
  function addr_match;
    input [7:0] rx;
    input [7:0] own;
    input ten;
    input seen_low;
    begin
      if (ten) begin
        addr_match = (rx[7:3] == `TEN_BIT_PREFIX) && (rx[2:1] == own[2:1])
          && (~rx[0] | seen_low);
      end else begin
        addr_match = (rx[7:1] == own[7:1]);
      end
    end
  endfunction

  assign first_hit = addr_match(shreg, slave_address_reg, TEN_BIT_EN_IN, ten_matched);

  // ----------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------
  i2c_pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .async_in({SCL_IN, SDA_IN}),
    .sync_out(pins_sync)
  );

  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  // delayed copies of the synchronised levels for edges
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------
  // protocol engine and software flags
  // ----------------------------------------
  // software actions first; later hardware assignments win the same cycle
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state <= ST_IDLE;
      cnt <= `CNT_ZERO;
      shreg <= `BYTE_RESET;
      tx_sh <= `BYTE_RESET;
      kind <= KIND_ADDR;
      kind_after <= KIND_ADDR;
      ack_drive <= 1'b0;
      ua_pending <= 1'b0;
      ten_matched <= 1'b0;
      serial_irq_flag <= 1'b0;
      clock_release_bit <= `CKP_RESET;
      buffer_full_flag <= 1'b0;
      update_address_flag <= 1'b0;
      ack_timing_status <= 1'b0;
      received_ack_status <= 1'b0;
      read_write <= 1'b0;
      data_address <= 1'b0;
      start_seen <= 1'b0;
      slave_address_reg <= `ADDR_RESET;
      fifo_in_valid <= 1'b0;
      fifo_in_data <= `BYTE_RESET;
    end else begin
      fifo_in_valid <= 1'b0;
      if (IRQ_CLEAR_IN) begin
        serial_irq_flag <= 1'b0;
      end
      if (CLK_RELEASE_SET_IN) begin
        clock_release_bit <= 1'b1;
      end
      if (rx_pop) begin
        buffer_full_flag <= 1'b0;
      end
      if (ADDR_WR_IN) begin
        slave_address_reg <= ADDR_WR_DATA_IN;
        update_address_flag <= 1'b0;
      end
      if (TX_WR_IN) begin
        tx_sh <= TX_DATA_IN;
        buffer_full_flag <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          cnt <= `CNT_ZERO;
        end
        ST_RECV: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            cnt <= cnt + `CNT_ONE;
          end else if (scl_fall && cnt == `BYTE_BITS) begin
            if (kind == KIND_ADDR) begin
              if (first_hit) begin
                read_write <= shreg[0];
                data_address <= 1'b0;
                fifo_in_valid <= 1'b1;
                fifo_in_data <= shreg;
                buffer_full_flag <= 1'b1;
                // only a 10-bit high write byte waits for the address update
                ua_pending <= TEN_BIT_EN_IN & ~shreg[0];
                kind_after <= (TEN_BIT_EN_IN & ~shreg[0]) ? KIND_LOW : KIND_DATA;
                if (ADDR_HOLD_EN_IN) begin
                  clock_release_bit <= 1'b0;
                  serial_irq_flag <= 1'b1;
                  ack_timing_status <= 1'b1;
                  state <= ST_HOLD;
                end else begin
                  ack_drive <= fifo_in_ready;
                  ack_timing_status <= 1'b1;
                  state <= ST_ACK;
                end
              end else begin
                state <= ST_IDLE;
              end
            end else if (kind == KIND_LOW) begin
              // mismatch still reports so software can restore the high byte
              ua_pending <= 1'b1;
              kind_after <= KIND_DATA;
              ack_timing_status <= 1'b1;
              if (shreg == slave_address_reg) begin
                fifo_in_valid <= 1'b1;
                fifo_in_data <= shreg;
                buffer_full_flag <= 1'b1;
                ten_matched <= 1'b1;
                ack_drive <= fifo_in_ready;
              end else begin
                ack_drive <= 1'b0;
              end
              state <= ST_ACK;
            end else begin
              data_address <= 1'b1;
              fifo_in_valid <= 1'b1;
              fifo_in_data <= shreg;
              buffer_full_flag <= 1'b1;
              ack_timing_status <= 1'b1;
              if (DATA_HOLD_EN_IN) begin
                clock_release_bit <= 1'b0;
                serial_irq_flag <= 1'b1;
                state <= ST_HOLD;
              end else begin
                // full fifo answers nack instead of losing a byte
                ack_drive <= fifo_in_ready;
                state <= ST_ACK;
              end
            end
          end
        end
        ST_HOLD: begin
          // software has set the release bit: send its chosen ack value
          if (clock_release_bit) begin
            ack_drive <= ~ACK_VALUE_IN;
            state <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            ack_drive <= 1'b0;
            ack_timing_status <= 1'b0;
            ua_pending <= 1'b0;
            cnt <= `CNT_ZERO;
            kind <= kind_after;
            if (ua_pending) begin
              update_address_flag <= 1'b1;
              serial_irq_flag <= 1'b1;
            end
            if (!ack_drive) begin
              state <= ST_IDLE;
            end else begin
              serial_irq_flag <= 1'b1;
              if (read_write && kind == KIND_ADDR) begin
                clock_release_bit <= 1'b0;
                state <= ST_TX;
              end else begin
                if (STRETCH_EN_IN) begin
                  clock_release_bit <= 1'b0;
                end
                state <= ST_RECV;
              end
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            tx_sh <= {tx_sh[6:0], 1'b0};
            cnt <= cnt + `CNT_ONE;
            if (cnt + `CNT_ONE == `BYTE_BITS) begin
              buffer_full_flag <= 1'b0;
              state <= ST_TXACK;
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            received_ack_status <= sda_s;
          end else if (scl_fall) begin
            serial_irq_flag <= 1'b1;
            cnt <= `CNT_ZERO;
            if (!received_ack_status) begin
              clock_release_bit <= 1'b0;
              state <= ST_TX;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // bus conditions override any byte in progress
      if (start_det) begin
        state <= ST_RECV;
        kind <= KIND_ADDR;
        cnt <= `CNT_ZERO;
        ack_drive <= 1'b0;
        ua_pending <= 1'b0;
        start_seen <= 1'b1;
        if (START_IRQ_EN_IN) begin
          serial_irq_flag <= 1'b1;
        end
      end else if (stop_det) begin
        state <= ST_IDLE;
        ack_drive <= 1'b0;
        ua_pending <= 1'b0;
        ten_matched <= 1'b0;
        start_seen <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  // hold only once SCL is seen low so the master's high time is kept;
  // the hold state keeps SCL low until the chosen ack is on SDA, else a false start
  assign need_hold = ~clock_release_bit | update_address_flag | (state == ST_HOLD);

  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      scl_oe_n <= ~(need_hold & (~scl_oe_n | ~scl_s));
      sda_oe_n <= ~((state == ST_ACK && ack_drive) || (state == ST_TX && !tx_sh[7]));
    end
  end

  assign SCL_OUT = `PIN_LOW;
  assign SDA_OUT = `PIN_LOW;
  assign SCL_OE_N_OUT = scl_oe_n;
  assign SDA_OE_N_OUT = sda_oe_n;

  // ----------------------------------------
  // receive buffering
  // ----------------------------------------
  i2c_rx_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_in_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_drain),
    .out_data_out(fifo_out_data)
  );

  // output stage keeps the read port registered
  assign fifo_drain = ~rx_valid | RX_READY_IN;
  assign rx_pop = rx_valid & RX_READY_IN;

  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rx_valid <= 1'b0;
      rx_data <= {DATA_W{1'b0}};
    end else if (fifo_drain) begin
      rx_valid <= fifo_out_valid;
      rx_data <= fifo_out_data;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  assign RX_VALID_OUT = rx_valid;
  assign RX_DATA_OUT = rx_data;
  assign SERIAL_IRQ_FLAG_OUT = serial_irq_flag;
  assign CLOCK_RELEASE_BIT_OUT = clock_release_bit;
  assign BUFFER_FULL_FLAG_OUT = buffer_full_flag;
  assign UPDATE_ADDRESS_FLAG_OUT = update_address_flag;
  assign ACK_TIMING_STATUS_OUT = ack_timing_status;
  assign RECEIVED_ACK_STATUS_OUT = received_ack_status;
  assign READ_WRITE_STATUS_OUT = read_write;
  assign DATA_ADDRESS_STATUS_OUT = data_address;
  assign START_SEEN_OUT = start_seen;
  assign SLAVE_ADDRESS_OUT = slave_address_reg;
endmodule // i2c_slave_stretch_addr_hold
`default_nettype wire

// [core/i2c_slave_defines.vh]
// shared constants of the i2c slave with clock stretching and address hold
`ifndef I2C_SLAVE_DEFINES_VH
`define I2C_SLAVE_DEFINES_VH
// ----------------------------------------
// byte framing
// ----------------------------------------
`define BYTE_BITS 4'h8
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define TEN_BIT_PREFIX 5'h1E
// ----------------------------------------
// reset values and driven pin level
// ----------------------------------------
`define ADDR_RESET 8'h00
`define BYTE_RESET 8'h00
`define CKP_RESET 1'b1
`define PIN_LOW 1'b0
// ----------------------------------------
// buffering defaults
// ----------------------------------------
`define DATA_WIDTH 8
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

// [core/i2c_pin_sync.v]
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module i2c_pin_sync #(
  parameter WIDTH = 2
) (
  input wire clk_in,
  input wire rst_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  // ----------------------------------------
  // synchroniser stages
  // ----------------------------------------
  reg [WIDTH-1:0] stage_one;
  reg [WIDTH-1:0] stage_two;

  // idle bus is high, so reset to ones
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage_one <= {WIDTH{1'b1}};
      stage_two <= {WIDTH{1'b1}};
    end else begin
      stage_one <= async_in;
      stage_two <= stage_one;
    end
  end

  assign sync_out = stage_two;
endmodule // i2c_pin_sync
`default_nettype wire

// [core/i2c_rx_fifo.v]
// receive fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module i2c_rx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_in,
  input wire rst_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  // ----------------------------------------
  // storage and pointers
  // ----------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire full;
  wire empty;
  wire do_wr;
  wire do_rd;

  // extra pointer bit tells full from empty
  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready_out = ~full;
  assign out_valid_out = ~empty;
  assign out_data_out = mem[rd_ptr[AW-1:0]];
  assign do_wr = in_valid_in & ~full;
  assign do_rd = out_ready_in & ~empty;

  // memory write, no reset needed on data
  always @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  // pointer update
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // i2c_rx_fifo
`default_nettype wire

// [test/i2c_slave_stretch_addr_hold_monitor.sv]
// port checker of the i2c slave engine, bound onto its top module
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_stretch_addr_hold_monitor (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic SCL_IN,
  input wire logic SCL_OE_N_OUT,
  input wire logic SDA_OE_N_OUT,
  input wire logic ADDR_HOLD_EN_IN,
  input wire logic STRETCH_EN_IN,
  input wire logic START_IRQ_EN_IN,
  input wire logic TEN_BIT_EN_IN,
  input wire logic TX_WR_IN,
  input wire logic SERIAL_IRQ_FLAG_OUT,
  input wire logic CLOCK_RELEASE_BIT_OUT,
  input wire logic BUFFER_FULL_FLAG_OUT,
  input wire logic UPDATE_ADDRESS_FLAG_OUT,
  input wire logic ACK_TIMING_STATUS_OUT,
  input wire logic RECEIVED_ACK_STATUS_OUT,
  input wire logic DATA_ADDRESS_STATUS_OUT,
  input wire logic START_SEEN_OUT
);
  // ----------------------------------------
  // one clock domain, reset disables all
  // ----------------------------------------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  // pulling early would cut the master's high time short
  a_hold_after_low: assert property ($fell(SCL_OE_N_OUT) |-> !SCL_IN && !$past(SCL_IN, 2))
    else $error("slave pulled scl before it was low");
  a_hold_until_set: assert property (!SCL_OE_N_OUT && !CLOCK_RELEASE_BIT_OUT ##1 !CLOCK_RELEASE_BIT_OUT |-> !SCL_OE_N_OUT)
    else $error("scl let go while release bit clear");
  a_set_frees_scl: assert property ($rose(CLOCK_RELEASE_BIT_OUT) && !UPDATE_ADDRESS_FLAG_OUT |-> ##[0:2] SCL_OE_N_OUT)
    else $error("scl still held after release bit set");
  a_ua_holds_scl: assert property ($rose(UPDATE_ADDRESS_FLAG_OUT) |-> ##[0:3] (!SCL_OE_N_OUT || !UPDATE_ADDRESS_FLAG_OUT))
    else $error("update address set but scl not held");
  a_ua_keeps_bit: assert property ($rose(UPDATE_ADDRESS_FLAG_OUT) && !STRETCH_EN_IN |-> $stable(CLOCK_RELEASE_BIT_OUT))
    else $error("release bit changed with update address");
  a_ua_write_frees: assert property ($fell(UPDATE_ADDRESS_FLAG_OUT) && CLOCK_RELEASE_BIT_OUT |-> ##[0:1] SCL_OE_N_OUT)
    else $error("scl held after address write");
  a_tx_sets_full: assert property (TX_WR_IN |=> BUFFER_FULL_FLAG_OUT)
    else $error("buffer full not set by transmit load");
  a_start_raises_irq: assert property ($rose(START_SEEN_OUT) && START_IRQ_EN_IN |-> ##[0:1] SERIAL_IRQ_FLAG_OUT)
    else $error("start seen without interrupt");
  a_addr_hold_stop: assert property ($rose(ACK_TIMING_STATUS_OUT) && ADDR_HOLD_EN_IN && !TEN_BIT_EN_IN
    && !DATA_ADDRESS_STATUS_OUT |-> ##[0:1] (SERIAL_IRQ_FLAG_OUT && !CLOCK_RELEASE_BIT_OUT))
    else $error("address hold without interrupt and clear");
  a_nack_lets_go: assert property ($rose(RECEIVED_ACK_STATUS_OUT) |-> (SCL_OE_N_OUT && SDA_OE_N_OUT) [*8])
    else $error("bus driven after master nack");
endmodule  // i2c_slave_stretch_addr_hold_monitor
bind i2c_slave_stretch_addr_hold i2c_slave_stretch_addr_hold_monitor monitor_inst (.CLK_IN,
  .SYS_RST_IN, .SCL_IN, .SCL_OE_N_OUT, .SDA_OE_N_OUT, .ADDR_HOLD_EN_IN, .STRETCH_EN_IN,
  .START_IRQ_EN_IN, .TEN_BIT_EN_IN, .TX_WR_IN, .SERIAL_IRQ_FLAG_OUT, .CLOCK_RELEASE_BIT_OUT,
  .BUFFER_FULL_FLAG_OUT, .UPDATE_ADDRESS_FLAG_OUT, .ACK_TIMING_STATUS_OUT,
  .RECEIVED_ACK_STATUS_OUT, .DATA_ADDRESS_STATUS_OUT, .START_SEEN_OUT);
`default_nettype wire

// [test/i2c_master_model.sv]
// behavioural i2c bus master: start, stop, byte write and byte read
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
  input wire logic scl_line_in,
  input wire logic sda_line_in,
  output logic scl_rel_out,
  output logic sda_rel_out
);
  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  // both lines released; the clock stands still between frames
  initial begin
    scl_rel_out = 1'b1;
    sda_rel_out = 1'b1;
  end
  // data set in the low phase; a stretching slave delays the pulse
  task automatic bit_cycle(input logic drive, output logic smp);
    #40 sda_rel_out = drive;
    #110 scl_rel_out = 1'b1;
    wait (scl_line_in === 1'b1);
    #70 smp = sda_line_in;
    #100 scl_rel_out = 1'b0;
  endtask
  task automatic start();
    sda_rel_out = 1'b0;
    #160 scl_rel_out = 1'b0;
  endtask
  task automatic stop();
    #40 sda_rel_out = 1'b0;
    #110 scl_rel_out = 1'b1;
    wait (scl_line_in === 1'b1);
    #160 sda_rel_out = 1'b1;
    #160;
  endtask
  // msb first, then the slave's answer on the ninth pulse
  task automatic write_byte(input logic [7:0] data, output logic ack);
    logic smp;
    for (int i = 7; i >= 0; i--)
      bit_cycle(data[i], smp);
    bit_cycle(1'b1, ack);
  endtask
  task automatic read_byte(input logic nack, output logic [7:0] data);
    logic smp;
    for (int i = 7; i >= 0; i--)
      bit_cycle(1'b1, data[i]);
    bit_cycle(nack, smp);
  endtask
endmodule  // i2c_master_model
`default_nettype wire

// [test/i2c_slave_stretch_addr_hold_tb.sv]
// self-checking bench of the i2c slave engine against a bus master model
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_stretch_addr_hold_tb;
  // ----------------------------------------
  // design ports and the wired bus
  // ----------------------------------------
  logic CLK_IN = 1'b0, SYS_RST_IN = 1'b1, ADDR_HOLD_EN_IN = 1'b0, DATA_HOLD_EN_IN = 1'b0;
  logic STRETCH_EN_IN = 1'b0, START_IRQ_EN_IN = 1'b0, TEN_BIT_EN_IN = 1'b0, ACK_VALUE_IN = 1'b0;
  logic CLK_RELEASE_SET_IN = 1'b0, IRQ_CLEAR_IN = 1'b0, ADDR_WR_IN = 1'b0, TX_WR_IN = 1'b0;
  logic RX_READY_IN = 1'b0;
  logic [7:0] ADDR_WR_DATA_IN = 8'h00, TX_DATA_IN = 8'h00;
  wire logic SCL_IN, SDA_IN, SCL_OUT, SCL_OE_N_OUT, SDA_OUT, SDA_OE_N_OUT, RX_VALID_OUT;
  wire logic SERIAL_IRQ_FLAG_OUT, CLOCK_RELEASE_BIT_OUT, BUFFER_FULL_FLAG_OUT, START_SEEN_OUT;
  wire logic UPDATE_ADDRESS_FLAG_OUT, ACK_TIMING_STATUS_OUT, RECEIVED_ACK_STATUS_OUT;
  wire logic READ_WRITE_STATUS_OUT, DATA_ADDRESS_STATUS_OUT, scl_rel, sda_rel;
  wire logic [7:0] RX_DATA_OUT, SLAVE_ADDRESS_OUT;
  logic ack;
  logic [7:0] rd;
  int n_fail = 0;
  int total_checks = 0;
  // pull-ups: a line is low whenever any party pulls it
  assign SCL_IN = scl_rel & (SCL_OE_N_OUT | SCL_OUT);
  assign SDA_IN = sda_rel & (SDA_OE_N_OUT | SDA_OUT);
  always #20 CLK_IN = ~CLK_IN;
  i2c_slave_stretch_addr_hold i2c_slave_stretch_addr_hold_inst (.*);
  i2c_master_model i2c_master_model_inst (.scl_line_in(SCL_IN), .sda_line_in(SDA_IN),
    .scl_rel_out(scl_rel), .sda_rel_out(sda_rel));
  // ----------------------------------------
  // software-side access tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    total_checks++;
    if (seen !== expected) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, expected);
    end
  endtask
  // inputs only move at the falling edge, away from sampling
  task automatic tick(input int n);
    repeat (n) @(negedge CLK_IN);
  endtask
  task automatic sw_irq();
    int k;
    k = 0;
    do begin
      tick(1);
      k++;
    end while (SERIAL_IRQ_FLAG_OUT !== 1'b1 && k < 400);
    check(SERIAL_IRQ_FLAG_OUT, 1'h1);
    IRQ_CLEAR_IN = 1'b1;
    tick(1);
    IRQ_CLEAR_IN = 1'b0;
  endtask
  task automatic sw_release();
    tick(1);
    CLK_RELEASE_SET_IN = 1'b1;
    tick(1);
    CLK_RELEASE_SET_IN = 1'b0;
  endtask
  // one task writes either the address register or the transmit byte, picking the strobe by to_addr
  task automatic sw_write(input logic to_addr, input logic [7:0] d);
    tick(1);
    ADDR_WR_DATA_IN = d;
    TX_DATA_IN = d;
    ADDR_WR_IN = to_addr;
    TX_WR_IN = !to_addr;
    tick(1);
    ADDR_WR_IN = 1'b0;
    TX_WR_IN = 1'b0;
    tick(1);
  endtask
  task automatic pop(input logic [7:0] expected);
    int k;
    k = 0;
    while (RX_VALID_OUT !== 1'b1 && k < 50) begin
      tick(1);
      k++;
    end
    check(RX_DATA_OUT, expected);
    RX_READY_IN = 1'b1;
    tick(1);
    RX_READY_IN = 1'b0;
    tick(1);
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    tick(5);
    SYS_RST_IN = 1'b0;
    tick(4);
    check({SCL_OE_N_OUT, SDA_OE_N_OUT, CLOCK_RELEASE_BIT_OUT, SERIAL_IRQ_FLAG_OUT,
      BUFFER_FULL_FLAG_OUT, UPDATE_ADDRESS_FLAG_OUT, START_SEEN_OUT, RX_VALID_OUT}, 8'hE0);
    check({SCL_OUT, SDA_OUT}, 8'h00);
    sw_write(1'b1, 8'hA0);
    check(SLAVE_ADDRESS_OUT, 8'hA0);
    // 7-bit read with address hold: one byte acked, the last refused
    ADDR_HOLD_EN_IN = 1'b1;
    START_IRQ_EN_IN = 1'b1;
    i2c_master_model_inst.start();
    sw_irq();
    check(START_SEEN_OUT, 1'h1);
    fork
      i2c_master_model_inst.write_byte(8'hA1, ack);
      begin
        sw_irq();
        check({CLOCK_RELEASE_BIT_OUT, ACK_TIMING_STATUS_OUT, READ_WRITE_STATUS_OUT,
          DATA_ADDRESS_STATUS_OUT}, 8'h06);
        pop(8'hA1);
        check(BUFFER_FULL_FLAG_OUT, 1'h0);
        ACK_VALUE_IN = 1'b0;
        sw_release();
      end
    join
    check(ack, 1'h0);
    sw_irq();
    check(CLOCK_RELEASE_BIT_OUT, 1'h0);
    for (int i = 0; i < 2; i++) begin
      sw_write(1'b0, i ? 8'hC3 : 8'h5A);
      check(BUFFER_FULL_FLAG_OUT, 1'h1);
      sw_release();
      i2c_master_model_inst.read_byte(i[0], rd);
      check(rd, i ? 8'hC3 : 8'h5A);
      check(RECEIVED_ACK_STATUS_OUT, i[0]);
      sw_irq();
      tick(6);
      check(SCL_OE_N_OUT, i[0]);
    end
    i2c_master_model_inst.stop();
    $display("test done: read with address hold");
    // 7-bit write with data hold and stretch, data byte refused
    ADDR_HOLD_EN_IN = 1'b0;
    START_IRQ_EN_IN = 1'b0;
    DATA_HOLD_EN_IN = 1'b1;
    STRETCH_EN_IN = 1'b1;
    i2c_master_model_inst.start();
    tick(8);
    check(SERIAL_IRQ_FLAG_OUT, 1'h0);
    i2c_master_model_inst.write_byte(8'hA0, ack);
    check(ack, 1'h0);
    sw_irq();
    check({CLOCK_RELEASE_BIT_OUT, READ_WRITE_STATUS_OUT, DATA_ADDRESS_STATUS_OUT}, 8'h00);
    pop(8'hA0);
    sw_release();
    fork
      i2c_master_model_inst.write_byte(8'h96, ack);
      begin
        sw_irq();
        check({CLOCK_RELEASE_BIT_OUT, ACK_TIMING_STATUS_OUT, DATA_ADDRESS_STATUS_OUT}, 8'h03);
        ACK_VALUE_IN = 1'b1;
        sw_release();
      end
    join
    check(ack, 1'h1);
    tick(20);
    check(SERIAL_IRQ_FLAG_OUT, 1'h0);
    i2c_master_model_inst.stop();
    RX_READY_IN = 1'b1;
    tick(20);
    RX_READY_IN = 1'b0;
    $display("test done: write with data hold");
    // 10-bit write: high byte matches, low byte does not
    DATA_HOLD_EN_IN = 1'b0;
    STRETCH_EN_IN = 1'b0;
    ACK_VALUE_IN = 1'b0;
    TEN_BIT_EN_IN = 1'b1;
    sw_write(1'b1, 8'hF0);
    i2c_master_model_inst.start();
    i2c_master_model_inst.write_byte(8'hF0, ack);
    check(ack, 1'h0);
    sw_irq();
    tick(2);
    check({UPDATE_ADDRESS_FLAG_OUT, CLOCK_RELEASE_BIT_OUT, SCL_OE_N_OUT}, 8'h06);
    pop(8'hF0);
    sw_write(1'b1, 8'h34);
    check({UPDATE_ADDRESS_FLAG_OUT, SCL_OE_N_OUT}, 8'h01);
    i2c_master_model_inst.write_byte(8'h35, ack);
    check(ack, 1'h1);
    sw_irq();
    check({UPDATE_ADDRESS_FLAG_OUT, BUFFER_FULL_FLAG_OUT, CLOCK_RELEASE_BIT_OUT}, 8'h05);
    sw_write(1'b1, 8'hF0);
    i2c_master_model_inst.stop();
    tick(4);
    check({START_SEEN_OUT, RX_VALID_OUT}, 8'h00);
    $display("test done: ten-bit address");
    summarize();
  end
  // watchdog: the whole sequence needs well under this span
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
endmodule  // i2c_slave_stretch_addr_hold_tb
`default_nettype wire
